// ---- inc/imdr_regs.svh ----
// Purpose: constants for the input module diagnostic record tail
// Assumes: byte-wide record read by index over the module's record port
// Notes: record indices follow the diagnostic record byte order
// Function
// (R1) channel_kind_byte bits 6..0 read 70h digital input, bit 7 reserved zero
// (R2) diag_bits_per_channel reads 00h
// (R3) channel_count_byte reads 02h, two input channels
// (R4) channel_fault_byte bit0/bit1 set when an edge on input_0/input_1 is lost
// (R5) diag_timestamp captures full 32-bit ticker when a diagnostic is raised
// (R6) 32-bit microsecond ticker cleared at power-on, then counts
// (R7) ticker wraps from 2^32-1 to zero and continues
// (R8) module_diag_byte bit 3 set whenever a channel error is present
// (R9) extended_diag_byte bit 6 set when a process interrupt is lost; code sets it only on a raise from idle, losses while active discarded
// (R10) going event raised once cause gone; channel events in between discarded
`ifndef IMDR_REGS_SVH
`define IMDR_REGS_SVH
`define IMDR_IDX_MODULE_DIAG   5'h00
`define IMDR_IDX_EXT_DIAG      5'h03
`define IMDR_IDX_CHANNEL_KIND  5'h04
`define IMDR_IDX_DIAG_BITS     5'h05
`define IMDR_IDX_CHANNEL_COUNT 5'h06
`define IMDR_IDX_CHANNEL_FAULT 5'h07
`define IMDR_IDX_PERCH_FIRST   5'h08
`define IMDR_IDX_PERCH_LAST    5'h0F
`define IMDR_IDX_TS_FIRST      5'h10
`define IMDR_IDX_TS_B1         5'h11
`define IMDR_IDX_TS_B2         5'h12
`define IMDR_IDX_TS_LAST       5'h13
`define IMDR_VAL_CHANNEL_KIND  8'h70
`define IMDR_VAL_DIAG_BITS     8'h00
`define IMDR_VAL_CHANNEL_COUNT 8'h02
`define IMDR_BIT_CHAN_ERR      3
`define IMDR_BIT_IRQ_LOST      6
`define IMDR_TICK_NS           1000
`define IMDR_CLK_NS            4
`endif

// ---- inc/imdr_pkg.sv ----
// Purpose: types for the diagnostic record tail
// Assumes: none
// Notes: gray-coded diagnostic state
`default_nettype none
package imdr_pkg;
  typedef enum logic [1:0] {
    IMDR_IDLE  = 2'b00,
    IMDR_ACTIVE = 2'b01
  } imdr_state_t;
endpackage
`default_nettype wire

// ---- src/imdr_record.sv ----
// Purpose: diagnostic record tail with microsecond ticker and timestamp capture
// Assumes: record reads are synchronous byte reads by index
// Notes: fault inputs are one-cycle event pulses from the edge logic
`timescale 1ns/100ps
`default_nettype none
`include "imdr_regs.svh"
module imdr_record
  import imdr_pkg::*;
#(
  parameter int CHANNELS = 2
) (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic [1:0] edge_lost,
  input  wire logic       irq_lost,
  input  wire logic       cause_clear,
  input  wire logic       rd_en,
  input  wire logic [4:0] rd_idx,
  output var  logic [7:0] rd_data,
  output var  logic       rd_valid,
  output var  logic       diag_incoming,
  output var  logic       diag_going
);
  localparam int TICK_CYC = `IMDR_TICK_NS / `IMDR_CLK_NS;
  localparam int PRE_W = $clog2(TICK_CYC);

  // refuse settings the logic cannot serve
  if (CHANNELS != 2) begin : g_bad_channels
    $error("imdr_record serves exactly two channels");
  end
  if (TICK_CYC < 2) begin : g_bad_tick
    $error("imdr_record needs at least two clocks per tick");
  end

  logic [PRE_W-1:0] prescale;
  logic [31:0]      ticker;
  logic [31:0]      diag_timestamp;
  logic [1:0]       channel_fault;
  logic             ext_irq_lost;
  imdr_state_t      state;
  logic             raise;
  logic             tick;

  assign tick = (prescale == PRE_W'(TICK_CYC - 1));

  // (R6) power-on clear ticker
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prescale <= '0;
      ticker   <= '0;
    end else begin
      prescale <= tick ? '0 : prescale + 1'b1;
      // (R7) natural wrap to zero
      if (tick) begin
        ticker <= ticker + 32'h0000_0001;
      end
    end
  end

  assign raise = (state == IMDR_IDLE) && ((|edge_lost) || irq_lost);

  // (R10) incoming then automatic going
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state         <= IMDR_IDLE;
      diag_incoming <= 1'b0;
      diag_going    <= 1'b0;
    end else begin
      diag_incoming <= raise;
      diag_going    <= 1'b0;
      unique case (state)
        IMDR_IDLE: begin
          if (raise) begin
            state <= IMDR_ACTIVE;
          end
        end
        IMDR_ACTIVE: begin
          if (cause_clear) begin
            state      <= IMDR_IDLE;
            diag_going <= 1'b1;
          end
        end
      endcase
    end
  end

  // (R4) edge lost flags, (R10) discarded while active
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      channel_fault <= 2'h0;
      ext_irq_lost  <= 1'b0;
    end else if (raise) begin
      channel_fault <= edge_lost;
      // (R9) interrupt lost flag
      ext_irq_lost  <= irq_lost;
    end else if (state == IMDR_ACTIVE && cause_clear) begin
      channel_fault <= 2'h0;
      ext_irq_lost  <= 1'b0;
    end
  end

  // (R5) timestamp on raise
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      diag_timestamp <= '0;
    end else if (raise) begin
      diag_timestamp <= ticker;
    end
  end

  function automatic logic [7:0] rec_byte(input logic [4:0] idx);
    logic [7:0] b;
    b = 8'h00;
    unique case (idx)
      // (R8) module level channel error
      `IMDR_IDX_MODULE_DIAG:   b[`IMDR_BIT_CHAN_ERR] = |channel_fault;
      `IMDR_IDX_EXT_DIAG:      b[`IMDR_BIT_IRQ_LOST] = ext_irq_lost;
      // (R1) channel kind
      `IMDR_IDX_CHANNEL_KIND:  b = `IMDR_VAL_CHANNEL_KIND;
      // (R2) diag bits count
      `IMDR_IDX_DIAG_BITS:     b = `IMDR_VAL_DIAG_BITS;
      // (R3) channel count
      `IMDR_IDX_CHANNEL_COUNT: b = `IMDR_VAL_CHANNEL_COUNT;
      `IMDR_IDX_CHANNEL_FAULT: b = {6'h00, channel_fault};
      `IMDR_IDX_TS_FIRST:      b = diag_timestamp[7:0];
      `IMDR_IDX_TS_B1:         b = diag_timestamp[15:8];
      `IMDR_IDX_TS_B2:         b = diag_timestamp[23:16];
      `IMDR_IDX_TS_LAST:       b = diag_timestamp[31:24];
      default:                 b = 8'h00;
    endcase
    return b;
  endfunction

  // record read port
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      rd_data  <= rd_en ? rec_byte(rd_idx) : 8'h00;
    end
  end

  chk_ticker_wrap: assert property (@(posedge mclk) disable iff (!rstn) // (R7)
    (tick && ticker == 32'hFFFF_FFFF) |=> ticker == 32'h0)
    else $error("ticker did not wrap");
  chk_ticker_step: assert property (@(posedge mclk) disable iff (!rstn) // (R6)
    tick |=> ticker == $past(ticker) + 32'h1)
    else $error("ticker did not advance");
  chk_stamp_capture: assert property (@(posedge mclk) disable iff (!rstn) // (R5)
    raise |=> diag_timestamp == $past(ticker))
    else $error("timestamp not captured");
  chk_fault_set: assert property (@(posedge mclk) disable iff (!rstn) // (R4)
    (raise && edge_lost[0]) |=> channel_fault[0])
    else $error("edge lost flag missing");
  chk_irq_lost_set: assert property (@(posedge mclk) disable iff (!rstn) // (R9)
    (raise && irq_lost) |=> ext_irq_lost)
    else $error("interrupt lost flag missing");
  sequence s_active_clear;
    state == IMDR_ACTIVE && cause_clear;
  endsequence
  chk_going_auto: assert property (@(posedge mclk) disable iff (!rstn) // (R10)
    s_active_clear |=> diag_going && state == IMDR_IDLE)
    else $error("going event missing");
  chk_discard_active: assert property (@(posedge mclk) disable iff (!rstn) // (R10)
    (state == IMDR_ACTIVE && !cause_clear) |=> $stable(channel_fault))
    else $error("channel event stored while active");
  chk_kind_read: assert property (@(posedge mclk) disable iff (!rstn) // (R1)
    (rd_en && rd_idx == `IMDR_IDX_CHANNEL_KIND) |=> rd_valid && rd_data == `IMDR_VAL_CHANNEL_KIND)
    else $error("channel kind wrong");
  chk_count_read: assert property (@(posedge mclk) disable iff (!rstn) // (R3)
    (rd_en && rd_idx == `IMDR_IDX_CHANNEL_COUNT) |=> rd_data == `IMDR_VAL_CHANNEL_COUNT)
    else $error("channel count wrong");
  chk_bits_read: assert property (@(posedge mclk) disable iff (!rstn) // (R2)
    (rd_en && rd_idx == `IMDR_IDX_DIAG_BITS) |=> rd_data == `IMDR_VAL_DIAG_BITS)
    else $error("diag bits wrong");
  chk_module_flag: assert property (@(posedge mclk) disable iff (!rstn) // (R8)
    (rd_en && rd_idx == `IMDR_IDX_MODULE_DIAG && |channel_fault) |=> rd_data[`IMDR_BIT_CHAN_ERR])
    else $error("module channel error flag missing");

  // event and flag checks
  sequence s_raise;
    raise;
  endsequence
  chk_fault_set_hi: assert property (@(posedge mclk) disable iff (!rstn) // (R4)
    (raise && edge_lost[1]) |=> channel_fault[1])
    else $error("second edge lost flag missing");
  chk_incoming_pulse: assert property (@(posedge mclk) disable iff (!rstn) // (R10)
    s_raise |=> diag_incoming && state == IMDR_ACTIVE)
    else $error("incoming event missing");
  chk_incoming_only: assert property (@(posedge mclk) disable iff (!rstn) // (R10)
    !raise |=> !diag_incoming)
    else $error("incoming event without raise");
  chk_flags_clear: assert property (@(posedge mclk) disable iff (!rstn) // (R10)
    s_active_clear |=> channel_fault == '0 && !ext_irq_lost)
    else $error("flags not cleared on going");
  chk_going_idle: assert property (@(posedge mclk) disable iff (!rstn) // (R10)
    (state == IMDR_IDLE) |=> !diag_going)
    else $error("going event while idle");

  // ticker checks
  chk_ticker_hold: assert property (@(posedge mclk) disable iff (!rstn) // (R6)
    !tick |=> $stable(ticker))
    else $error("ticker moved between steps");
  chk_prescale_range: assert property (@(posedge mclk) disable iff (!rstn) // (R6)
    int'(prescale) < TICK_CYC)
    else $error("prescaler out of range");

  // record read checks
  chk_fault_read: assert property (@(posedge mclk) disable iff (!rstn) // (R4)
    (rd_en && rd_idx == `IMDR_IDX_CHANNEL_FAULT) |=> rd_data == 8'($past(channel_fault)))
    else $error("channel fault byte wrong");
  chk_ext_read: assert property (@(posedge mclk) disable iff (!rstn) // (R9)
    (rd_en && rd_idx == `IMDR_IDX_EXT_DIAG) |=> rd_data[`IMDR_BIT_IRQ_LOST] == $past(ext_irq_lost))
    else $error("interrupt lost bit wrong");
  chk_stamp_read: assert property (@(posedge mclk) disable iff (!rstn) // (R5)
    (rd_en && rd_idx == `IMDR_IDX_TS_FIRST) |=> rd_data == $past(diag_timestamp[7:0]))
    else $error("timestamp byte wrong");
  chk_module_clear: assert property (@(posedge mclk) disable iff (!rstn) // (R8)
    (rd_en && rd_idx == `IMDR_IDX_MODULE_DIAG && !(|channel_fault)) |=> !rd_data[`IMDR_BIT_CHAN_ERR])
    else $error("module channel error flag stuck");
endmodule // imdr_record
`default_nettype wire

// ---- test/imdr_reader.sv ----
// Purpose: backplane reader model for the record port
// Assumes: one read in flight at a time
// Notes: index lines toggle while no read is requested
`timescale 1ns/100ps
`default_nettype none
module imdr_reader (
  input  wire logic       mclk,
  input  wire logic       go,
  input  wire logic [4:0] idx,
  input  wire logic       rd_valid,
  input  wire logic [7:0] rd_data,
  output var  logic       rd_en,
  output var  logic [4:0] rd_idx,
  output var  logic [7:0] data,
  output var  logic       done
);
  initial begin
    rd_en = 1'b0;
    rd_idx = 5'h00;
    data = 8'h00;
    done = 1'b0;
  end
  always @(posedge mclk) begin
    rd_en <= go;
    rd_idx <= go ? idx : ~rd_idx;
    done <= rd_valid;
    if (rd_valid) begin
      data <= rd_data;
    end
  end
endmodule // imdr_reader
`default_nettype wire

// ---- test/tb.sv ----
// Purpose: self-checking bench for the diagnostic record tail
// Assumes: raises are spaced well away from ticker steps
// Notes: wrap of the ticker is too long to reach here
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin errors++; \
  $display("mismatch %s exp %0h got %0h", nm, ex, got); end end
module tb;
  import imdr_pkg::*;
  logic       mclk, rstn, irq_lost, cause_clear, go, rd_en, rd_valid, done;
  logic       diag_incoming, diag_going;
  logic [1:0] edge_lost;
  logic [4:0] idx, rd_idx;
  logic [7:0] rd_data, data, d;
  int         errors, cmp_count, cyc, n;
  logic [4:0] ri[11] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0F, 5'h10, 5'h13,
                         5'h00, 5'h03, 5'h1F};
  logic [7:0] re[11] = '{8'h70, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                         8'h00, 8'h00, 8'h00};
  imdr_record uut (.mclk(mclk), .rstn(rstn), .edge_lost(edge_lost), .irq_lost(irq_lost),
    .cause_clear(cause_clear), .rd_en(rd_en), .rd_idx(rd_idx), .rd_data(rd_data),
    .rd_valid(rd_valid), .diag_incoming(diag_incoming), .diag_going(diag_going));
  imdr_reader host (.mclk(mclk), .go(go), .idx(idx), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_en(rd_en), .rd_idx(rd_idx), .data(data), .done(done));
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;
  always @(posedge mclk) if (rstn) cyc <= cyc + 1;
  task automatic close_out;
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic rd(input logic [4:0] i, output logic [7:0] v);
    int k;
    @(posedge mclk);
    go <= 1'b1;
    idx <= i;
    @(posedge mclk);
    go <= 1'b0;
    for (k = 0; k < 8 && done !== 1'b1; k++) @(posedge mclk);
    if (done !== 1'b1) begin
      errors++;
      close_out;
    end
    v = data;
  endtask
  task automatic ev(input logic [1:0] el, input logic il, input logic cc);
    @(posedge mclk);
    edge_lost <= el;
    irq_lost <= il;
    cause_clear <= cc;
    @(posedge mclk);
    edge_lost <= 2'b00;
    irq_lost <= 1'b0;
    cause_clear <= 1'b0;
    @(negedge mclk);
  endtask
  initial begin
    {rstn, irq_lost, cause_clear, go, edge_lost, idx} = '0;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    for (n = 0; n < 11; n++) begin
      rd(ri[n], d);
      `CHK("record", re[n], d)
    end
    ev(2'b01, 1'b0, 1'b0);
    `CHK("incoming", 1'b1, diag_incoming)
    rd(5'h07, d);
    `CHK("fault", 8'h01, d)
    rd(5'h00, d);
    `CHK("module", 8'h08, d)
    rd(5'h10, d);
    `CHK("stamp0", 8'h00, d)
    ev(2'b10, 1'b1, 1'b0);
    `CHK("dropped", 1'b0, diag_incoming)
    rd(5'h07, d);
    `CHK("fault", 8'h01, d)
    rd(5'h03, d);
    `CHK("ext", 8'h00, d)
    ev(2'b00, 1'b0, 1'b1);
    `CHK("going", 1'b1, diag_going)
    rd(5'h07, d);
    `CHK("fault", 8'h00, d)
    rd(5'h00, d);
    `CHK("module", 8'h00, d)
    for (n = 0; n < 800 && cyc < 620; n++) @(posedge mclk);
    if (cyc < 620) begin
      errors++;
      close_out;
    end
    ev(2'b10, 1'b1, 1'b0);
    `CHK("incoming", 1'b1, diag_incoming)
    rd(5'h07, d);
    `CHK("fault", 8'h02, d)
    rd(5'h03, d);
    `CHK("ext", 8'h40, d)
    rd(5'h10, d);
    `CHK("stamp0", 8'h02, d)
    rd(5'h11, d);
    `CHK("stamp1", 8'h00, d)
    rd(5'h13, d);
    `CHK("stamp3", 8'h00, d)
    ev(2'b00, 1'b0, 1'b1);
    `CHK("going", 1'b1, diag_going)
    ev(2'b00, 1'b1, 1'b0);
    `CHK("incoming", 1'b1, diag_incoming)
    rd(5'h00, d);
    `CHK("module", 8'h00, d)
    rd(5'h03, d);
    `CHK("ext", 8'h40, d)
    @(posedge mclk);
    rstn <= 1'b0;
    @(negedge mclk);
    `CHK("rst_incoming", 1'b0, diag_incoming)
    `CHK("rst_going", 1'b0, diag_going)
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    rd(5'h03, d);
    `CHK("rst_ext", 8'h00, d)
    ev(2'b01, 1'b0, 1'b0);
    `CHK("incoming", 1'b1, diag_incoming)
    rd(5'h10, d);
    `CHK("restart0", 8'h00, d)
    close_out;
  end
endmodule // tb
`undef CHK
`default_nettype wire
